/* logic/pps_sequencer.sv */
// Panel power sequencer with identification buffer and register access from two hosts.
// Operation
// RULE1: Drive hot-plug high once start-up completes.
// RULE2: Source initializes aux, trains link, then sends video after hot-plug.
// RULE3: On valid video raise panel power, start LVDS within 50 ms.
// RULE4: After panel power, drive LVDS and set lock bit at 0x205.
// RULE5: Wait over 200 ms after LVDS start before backlight on.
// RULE6: On D3 write, drop backlight before stopping LVDS.
// RULE7: On video loss drop panel power within 50 ms.
// RULE8: Source keeps video or idle during backlight-off and power-off delays.
// RULE9: In D3 pull LVDS weakly low, keep panel power and backlight low.
// RULE10: With power-down low, backlight low and LVDS weakly pulled low.
// RULE11: In D3 keep aux and hot-plug, float main link and LVDS, stop I2C.
// RULE12: Writing D0 returns the device to active state.
// RULE13: Deep power-saving stops every interface until power-down input rises.
// RULE14: Registers are reachable from both aux and I2C.
// RULE15: Register setting overrides strap setting.
// RULE16: Host programs registers at initialization after hot-plug is high.
// RULE17: Pass-through identification reads fetch panel data and return it.
// RULE18: Emulated identification served from 896 bytes, seven 128-byte blocks, programmable.
// RULE19: Strap sampled at start-up replaces stored emulation bit.
// RULE20: Strap low emulates from internal memory; strap high fetches from panel.
// RULE21: Internal reset released after qualified supply plus delay; reasserted on long dip.
// RULE22: Runs from internal recovered or oscillator clock, no reference input.
// RULE23: Panel power held low over 500 ms before rising again.
// RULE24: LVDS keeps running over 20 ms after backlight drops; on video loss the code stops LVDS at once, without this delay.
// RULE25: Leaving deep sleep needs power-down high then a reset pulse.
// RULE26: Power-down and reset pin both low enter deep power-saving.
`timescale 1ns/10ps
`include "pps_consts.svh"

module pps_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	// Pointers wrap by overflow, so only power-of-two depths keep them in step with the count.
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
	begin
		$error("pps_fifo depth must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// The clock is recovered from the stream or made by the on-chip oscillator outside this block.
// RULE22: single internal clock
module pps_sequencer #(
	parameter int unsigned T2_CYCLES = `PPS_MS_CYCLES(`PPS_T2_MS),
	parameter int unsigned T3_CYCLES = `PPS_MS_CYCLES(`PPS_T3_MS),
	parameter int unsigned T4_CYCLES = `PPS_MS_CYCLES(`PPS_T4_MS),
	parameter int unsigned T5_CYCLES = `PPS_MS_CYCLES(`PPS_T5_MS),
	parameter int unsigned T12_CYCLES = `PPS_MS_CYCLES(`PPS_T12_MS),
	parameter int unsigned FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Pins and supply monitor
	input wire logic rst_pin_n,
	input wire logic power_down_n,
	input wire logic emulation_strap,
	input wire logic supply_above_high,
	input wire logic supply_below_low,
	// Link status from the receiver
	input wire logic video_valid,
	input wire logic video_sync_lost,
	// Aux register access
	input wire logic aux_req_valid,
	input wire pps_pkg::pps_reg_req_t aux_req,
	output logic aux_req_ready,
	// I2C register access
	input wire logic i2c_req_valid,
	input wire pps_pkg::pps_reg_req_t i2c_req,
	output logic i2c_req_ready,
	// Register read answer
	output logic rsp_valid_q,
	output logic rsp_from_i2c_q,
	output logic [7:0] rsp_data_q,
	// Identification read requests and answers
	input wire logic edid_req_valid,
	input wire logic [9:0] edid_req_addr,
	output logic edid_req_ready,
	output logic edid_rsp_valid,
	output logic [7:0] edid_rsp_data,
	input wire logic edid_rsp_ready,
	// Panel display data channel
	output logic ddc_req_valid_q,
	output logic [9:0] ddc_req_addr_q,
	input wire logic ddc_rsp_valid,
	input wire logic [7:0] ddc_rsp_data,
	// Panel and link outputs
	output logic hot_plug_out_q,
	output logic panel_power_en_q,
	output logic backlight_en_q,
	output logic lvds_drive_q,
	output logic lvds_weak_pd_q,
	output logic main_link_hiz_q
);
	localparam int unsigned HIGH_CYCLES = `PPS_US_CYCLES(`PPS_T_HIGH_US) + `PPS_US_CYCLES(`PPS_T_PORP_US);
	localparam int unsigned LOW_CYCLES = `PPS_US_CYCLES(`PPS_T_LOW_US);
	if (T2_CYCLES < 1 || T3_CYCLES < 1 || T4_CYCLES < 1 || T5_CYCLES < 1 || T12_CYCLES < 1)
	begin
		$error("pps_sequencer delays must be at least one cycle");
	end
	if (FIFO_DEPTH < 2)
	begin
		$error("pps_sequencer fifo too shallow");
	end

	typedef enum {
		ST_WAIT_VIDEO,
		ST_PWR_ON,
		ST_BL_WAIT,
		ST_ACTIVE,
		ST_BL_OFF,
		ST_VID_OFF,
		ST_HOLD
	} pps_state_t;

	function automatic pps_pkg::pps_sel_t reg_sel(input logic [19:0] addr);
		if (addr == `PPS_ADDR_LOCK_STATUS)
			return pps_pkg::PPS_SEL_LOCK;
		if (addr == `PPS_ADDR_POWER_STATE)
			return pps_pkg::PPS_SEL_POWER;
		if (addr == `PPS_ADDR_EMUL_CFG)
			return pps_pkg::PPS_SEL_EMUL;
		return pps_pkg::PPS_SEL_NONE;
	endfunction

	function automatic logic is_edid(input logic [19:0] addr);
		return addr >= `PPS_ADDR_EDID_BASE && addr < `PPS_ADDR_EDID_BASE + 20'(`PPS_EDID_BYTES);
	endfunction

	// Pins arrive asynchronously, so every one passes two flops first.
	logic [4:0] meta_q;
	logic [4:0] sync_q;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta_q <= 5'h1B;
			sync_q <= 5'h1B;
		end
		else
		begin
			meta_q <= {rst_pin_n, power_down_n, emulation_strap, supply_above_high, supply_below_low};
			sync_q <= meta_q;
		end
	end
	logic pin_rst_n;
	logic pd_n;
	logic strap;
	logic sup_high;
	logic sup_low;
	assign {pin_rst_n, pd_n, strap, sup_high, sup_low} = sync_q;

	// RULE21: supply qualification counters
	logic por_q;
	logic [31:0] por_cnt_q;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			por_q <= 1'b1;
			por_cnt_q <= '0;
		end
		else if (por_q)
		begin
			por_cnt_q <= sup_high ? por_cnt_q + 1'b1 : '0;
			if (sup_high && por_cnt_q >= 32'(HIGH_CYCLES))
			begin
				por_q <= 1'b0;
				por_cnt_q <= '0;
			end
		end
		else
		begin
			// Dips shorter than the low time are ignored on purpose.
			por_cnt_q <= sup_low ? por_cnt_q + 1'b1 : '0;
			if (sup_low && por_cnt_q >= 32'(LOW_CYCLES))
			begin
				por_q <= 1'b1;
				por_cnt_q <= '0;
			end
		end
	end

	// RULE26: deep power-saving entry and exit
	logic deep_q;
	logic pin_rst_prev_q;
	always_ff @(posedge clk)
	begin
		if (srst || por_q)
		begin
			deep_q <= 1'b0;
			pin_rst_prev_q <= 1'b1;
		end
		else
		begin
			pin_rst_prev_q <= pin_rst_n;
			if (!pd_n && !pin_rst_n)
				deep_q <= 1'b1;
			// RULE13: leave only with power-down high
			else if (pd_n && pin_rst_n && !pin_rst_prev_q)
				deep_q <= 1'b0;
		end
	end

	// The reset pin serves as a power-on reset without a supply cycle.
	logic core_rst;
	assign core_rst = srst || por_q || !pin_rst_n || deep_q;

	// RULE19: strap caught after reset release
	logic started_q;
	logic strap_q;
	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			started_q <= 1'b0;
			strap_q <= 1'b0;
		end
		else if (!started_q)
		begin
			started_q <= 1'b1;
			strap_q <= strap;
		end
	end

	// Registers.
	logic [7:0] pwr_q;
	logic [7:0] emul_cfg_q;
	logic [7:0] edid_mem_q [`PPS_EDID_BYTES];
	logic low_power;
	logic lock;
	logic emulate;
	assign low_power = (pwr_q == `PPS_PWR_D3);
	// RULE15: register overrides strap
	assign emulate = emul_cfg_q[`PPS_EMUL_OVR_BIT] ? emul_cfg_q[`PPS_EMUL_VAL_BIT] : !strap_q;

	// RULE14: aux first, I2C when idle
	// RULE11: I2C stopped in low power
	assign aux_req_ready = !core_rst && started_q;
	assign i2c_req_ready = aux_req_ready && !low_power && !aux_req_valid;
	logic take;
	pps_pkg::pps_reg_req_t req;
	assign take = (aux_req_valid && aux_req_ready) || (i2c_req_valid && i2c_req_ready);
	assign req = aux_req_valid ? aux_req : i2c_req;
	logic [9:0] mem_idx;
	assign mem_idx = 10'(req.addr - `PPS_ADDR_EDID_BASE);

	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			pwr_q <= `PPS_PWR_D0;
			emul_cfg_q <= `PPS_EMUL_CFG_RST;
		end
		else if (take && req.wr)
		begin
			// RULE12: D0 write returns to active
			if (reg_sel(req.addr) == pps_pkg::PPS_SEL_POWER)
				pwr_q <= req.wdata;
			if (reg_sel(req.addr) == pps_pkg::PPS_SEL_EMUL)
				emul_cfg_q <= req.wdata;
		end
	end

	// RULE18: programmable emulation storage
	always_ff @(posedge clk)
	begin
		if (!core_rst && take && req.wr && is_edid(req.addr))
			edid_mem_q[mem_idx] <= req.wdata;
	end

	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			rsp_valid_q <= 1'b0;
			rsp_from_i2c_q <= 1'b0;
			rsp_data_q <= 8'h00;
		end
		else
		begin
			rsp_valid_q <= take && !req.wr;
			rsp_from_i2c_q <= !aux_req_valid;
			if (take && !req.wr)
			begin
				unique case (reg_sel(req.addr))
					pps_pkg::PPS_SEL_LOCK: rsp_data_q <= 8'(lock) << `PPS_LOCK_BIT;
					pps_pkg::PPS_SEL_POWER: rsp_data_q <= pwr_q;
					pps_pkg::PPS_SEL_EMUL: rsp_data_q <= emul_cfg_q;
					pps_pkg::PPS_SEL_NONE: rsp_data_q <= is_edid(req.addr) ? edid_mem_q[mem_idx] : 8'h00;
				endcase
			end
		end
	end

	// Identification path; the fifo stalls requests when the source stops draining.
	logic fifo_in_ready;
	logic fifo_push;
	logic [7:0] fifo_data;
	logic ddc_busy_q;
	logic edid_take;
	assign edid_req_ready = !core_rst && started_q && fifo_in_ready && !ddc_busy_q;
	assign edid_take = edid_req_valid && edid_req_ready;
	// RULE20: strap low emulates, high fetches
	assign fifo_push = (edid_take && emulate) || (ddc_busy_q && ddc_rsp_valid);
	assign fifo_data = ddc_busy_q ? ddc_rsp_data : edid_mem_q[edid_req_addr];

	// RULE17: pass-through fetch from panel
	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			ddc_busy_q <= 1'b0;
			ddc_req_valid_q <= 1'b0;
			ddc_req_addr_q <= 10'h000;
		end
		else if (ddc_busy_q)
		begin
			ddc_req_valid_q <= 1'b0;
			if (ddc_rsp_valid)
				ddc_busy_q <= 1'b0;
		end
		else if (edid_take && !emulate)
		begin
			ddc_busy_q <= 1'b1;
			ddc_req_valid_q <= 1'b1;
			ddc_req_addr_q <= edid_req_addr;
		end
	end

	pps_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.srst(core_rst),
		.in_valid(fifo_push),
		.in_data(fifo_data),
		.in_ready(fifo_in_ready),
		.out_valid(edid_rsp_valid),
		.out_data(edid_rsp_data),
		.out_ready(edid_rsp_ready)
	);

	// Panel sequencing.
	pps_state_t state_q;
	logic [31:0] tmr_q;
	logic video_ok;
	logic tmr_done;
	assign video_ok = video_valid && !video_sync_lost;
	assign tmr_done = (tmr_q == 32'h0000_0001);
	always_ff @(posedge clk)
	begin
		if (core_rst)
		begin
			// RULE23: hold panel low after any reset
			state_q <= ST_HOLD;
			tmr_q <= 32'(T12_CYCLES);
		end
		else
		begin
			if (tmr_q > 32'h0000_0001)
				tmr_q <= tmr_q - 1'b1;
			unique case (state_q)
				ST_WAIT_VIDEO:
				begin
					// RULE3: panel power on valid video
					if (video_ok && !low_power)
					begin
						state_q <= ST_PWR_ON;
						tmr_q <= 32'(T2_CYCLES);
					end
				end
				ST_PWR_ON, ST_BL_WAIT, ST_ACTIVE:
				begin
					// RULE7: video loss stops LVDS now
					if (!video_ok)
					begin
						state_q <= ST_VID_OFF;
						tmr_q <= 32'(T5_CYCLES);
					end
					// RULE6: D3 drops backlight first
					else if (low_power)
					begin
						state_q <= ST_BL_OFF;
						tmr_q <= 32'(T4_CYCLES);
					end
					// RULE3: LVDS start within limit
					else if (state_q == ST_PWR_ON && tmr_done)
					begin
						state_q <= ST_BL_WAIT;
						tmr_q <= 32'(T3_CYCLES);
					end
					// RULE5: backlight after long delay
					else if (state_q == ST_BL_WAIT && tmr_done)
						state_q <= ST_ACTIVE;
				end
				ST_BL_OFF:
				begin
					// RULE24: LVDS outlives backlight
					if (tmr_done || !video_ok)
					begin
						state_q <= ST_VID_OFF;
						tmr_q <= 32'(T5_CYCLES);
					end
				end
				ST_VID_OFF:
				begin
					// RULE7: panel power off after delay
					if (tmr_done)
					begin
						state_q <= ST_HOLD;
						tmr_q <= 32'(T12_CYCLES);
					end
				end
				ST_HOLD:
				begin
					// RULE23: minimum panel off time
					if (tmr_done)
						state_q <= ST_WAIT_VIDEO;
				end
			endcase
		end
	end

	// RULE4: lock shown while LVDS driven
	assign lock = lvds_drive_q;

	// Outputs are registered, so they trail the state by one cycle.
	always_ff @(posedge clk)
	begin
		if (srst || por_q)
		begin
			hot_plug_out_q <= 1'b0;
			panel_power_en_q <= 1'b0;
			backlight_en_q <= 1'b0;
			lvds_drive_q <= 1'b0;
			lvds_weak_pd_q <= 1'b1;
			main_link_hiz_q <= 1'b1;
		end
		else
		begin
			// RULE1: hot-plug after start-up
			hot_plug_out_q <= started_q && !core_rst;
			// RULE9: panel and backlight low in D3
			panel_power_en_q <= !core_rst && state_q inside {ST_PWR_ON, ST_BL_WAIT, ST_ACTIVE, ST_BL_OFF, ST_VID_OFF};
			// RULE10: backlight low when powered down
			backlight_en_q <= !core_rst && pd_n && state_q == ST_ACTIVE;
			lvds_drive_q <= !core_rst && pd_n && state_q inside {ST_BL_WAIT, ST_ACTIVE, ST_BL_OFF};
			// RULE9: weak pull-down whenever not driving
			lvds_weak_pd_q <= core_rst || !pd_n || !(state_q inside {ST_BL_WAIT, ST_ACTIVE, ST_BL_OFF});
			// RULE11: main link floated in low power
			main_link_hiz_q <= core_rst || low_power;
		end
	end
endmodule

/* include/pps_consts.svh */
// Addresses, field positions, reset values and timing figures of the panel power sequencer.
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH
`define PPS_CLK_KHZ 100000
`define PPS_ADDR_LOCK_STATUS 20'h00205
`define PPS_ADDR_POWER_STATE 20'h00600
`define PPS_ADDR_EMUL_CFG 20'h00710
`define PPS_ADDR_EDID_BASE 20'h80000
`define PPS_EDID_BYTES 896
`define PPS_EDID_BLOCK 128
`define PPS_PWR_D0 8'h01
`define PPS_PWR_D3 8'h02
`define PPS_LOCK_BIT 0
`define PPS_EMUL_VAL_BIT 0
`define PPS_EMUL_OVR_BIT 1
`define PPS_EMUL_CFG_RST 8'h00
`define PPS_T2_MS 10
`define PPS_T3_MS 210
`define PPS_T4_MS 25
`define PPS_T5_MS 40
`define PPS_T12_MS 510
`define PPS_T_HIGH_US 2
`define PPS_T_PORP_US 10
`define PPS_T_LOW_US 2
`define PPS_US_CYCLES(us) ((us) * (`PPS_CLK_KHZ / 1000))
`define PPS_MS_CYCLES(ms) ((ms) * `PPS_CLK_KHZ)
`endif

/* include/pps_pkg.sv */
// Types shared by the panel power sequencer.
package pps_pkg;
	typedef struct packed {
		logic wr;
		logic [19:0] addr;
		logic [7:0] wdata;
	} pps_reg_req_t;
	typedef enum logic [1:0] {
		PPS_SEL_NONE,
		PPS_SEL_LOCK,
		PPS_SEL_POWER,
		PPS_SEL_EMUL
	} pps_sel_t;
endpackage

/* dv/pps_sequencer_asserts.sv */
// Port-level assertions for the panel power sequencer.
`timescale 1ns/10ps
module pps_sequencer_asserts #(
	parameter int unsigned T3_CYCLES = 20,
	parameter int unsigned T12_CYCLES = 8
) (
	// Clock and resets
	input wire logic clk,
	input wire logic srst,
	input wire logic rst_pin_n,
	input wire logic power_down_n,
	// Link and register side
	input wire logic video_sync_lost,
	input wire logic aux_req_valid,
	input wire pps_pkg::pps_reg_req_t aux_req,
	input wire logic aux_req_ready,
	input wire logic i2c_req_ready,
	input wire logic rsp_valid_q,
	input wire logic rsp_from_i2c_q,
	// Panel side
	input wire logic hot_plug_out_q,
	input wire logic panel_power_en_q,
	input wire logic backlight_en_q,
	input wire logic lvds_drive_q,
	input wire logic lvds_weak_pd_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	int unsigned on_cnt_q;
	int unsigned off_cnt_q;
	// Counters stand in for long repetitions, which the tools would unroll.
	always_ff @(posedge clk)
	begin
		if (srst || !lvds_drive_q)
			on_cnt_q <= '0;
		else
			on_cnt_q <= on_cnt_q + 32'h1;
	end
	always_ff @(posedge clk)
	begin
		if (srst || panel_power_en_q)
			off_cnt_q <= '0;
		else
			off_cnt_q <= off_cnt_q + 32'h1;
	end
	sequence deep_req_s;
		(!power_down_n && !rst_pin_n) [*6];
	endsequence
	sequence lvds_tail_s;
		lvds_drive_q [*3];
	endsequence
	hpd_ready_a: assert property ($rose(hot_plug_out_q) |-> aux_req_ready && $past(aux_req_ready))
		else $error("hot-plug raised before start-up");
	lvds_after_power_a: assert property ($rose(lvds_drive_q) |-> panel_power_en_q && !lvds_weak_pd_q)
		else $error("lvds started without panel power");
	backlight_delay_a: assert property ($rose(backlight_en_q) |-> on_cnt_q >= T3_CYCLES - 1)
		else $error("backlight on too early");
	backlight_first_a: assert property ($fell(lvds_drive_q) |-> !backlight_en_q)
		else $error("lvds stopped with backlight on");
	video_tail_a: assert property ($fell(backlight_en_q) && lvds_drive_q |-> lvds_tail_s)
		else $error("lvds stopped too soon after backlight");
	loss_power_off_a: assert property ($rose(video_sync_lost) && panel_power_en_q |-> ##[1:12] !panel_power_en_q)
		else $error("panel power kept after sync loss");
	power_hold_a: assert property ($rose(panel_power_en_q) |-> off_cnt_q >= T12_CYCLES - 1)
		else $error("panel power off time too short");
	deep_outputs_a: assert property (deep_req_s |=> !backlight_en_q && !panel_power_en_q && lvds_weak_pd_q)
		else $error("deep sleep outputs wrong");
	deep_no_access_a: assert property (deep_req_s |-> !aux_req_ready && !i2c_req_ready && !hot_plug_out_q)
		else $error("interface open in deep sleep");
	read_answer_a: assert property (aux_req_valid && aux_req_ready && !aux_req.wr |=> rsp_valid_q && !rsp_from_i2c_q)
		else $error("aux read not answered");
	aux_priority_a: assert property (aux_req_valid |-> !i2c_req_ready)
		else $error("i2c taken beside aux");
endmodule
bind pps_sequencer pps_sequencer_asserts #(.T3_CYCLES(T3_CYCLES), .T12_CYCLES(T12_CYCLES)) chk_u (
	.clk(clk), .srst(srst), .rst_pin_n(rst_pin_n), .power_down_n(power_down_n),
	.video_sync_lost(video_sync_lost), .aux_req_valid(aux_req_valid), .aux_req(aux_req),
	.aux_req_ready(aux_req_ready), .i2c_req_ready(i2c_req_ready), .rsp_valid_q(rsp_valid_q),
	.rsp_from_i2c_q(rsp_from_i2c_q), .hot_plug_out_q(hot_plug_out_q), .panel_power_en_q(panel_power_en_q),
	.backlight_en_q(backlight_en_q), .lvds_drive_q(lvds_drive_q), .lvds_weak_pd_q(lvds_weak_pd_q)
);

/* dv/pps_panel_model.sv */
// Panel-side responder for identification fetches.
`timescale 1ns/10ps
module pps_panel_model (
	// Clock and pace
	input wire logic clk,
	input wire logic slow,
	// Fetch request and answer
	input wire logic ddc_req_valid_q,
	input wire logic [9:0] ddc_req_addr_q,
	output logic ddc_rsp_valid,
	output logic [7:0] ddc_rsp_data
);
	int wait_n = -1;
	logic [9:0] addr_q = 10'h0;
	initial
	begin
		ddc_rsp_valid = 1'h0;
		ddc_rsp_data = 8'h00;
	end
	always @(posedge clk)
	begin
		ddc_rsp_valid <= 1'h0;
		// Data toggles outside the answer so a stale byte never passes.
		ddc_rsp_data <= ~ddc_rsp_data;
		if (ddc_req_valid_q)
		begin
			addr_q <= ddc_req_addr_q;
			wait_n <= slow ? 6 : 0;
		end
		else if (wait_n == 0)
		begin
			ddc_rsp_valid <= 1'h1;
			ddc_rsp_data <= addr_q[7:0] ^ 8'hA5;
			wait_n <= -1;
		end
		else if (wait_n > 0)
			wait_n <= wait_n - 1;
	end
endmodule

/* dv/pps_sequencer_tb.sv */
// Self-checking bench for the panel power sequencer.
`timescale 1ns/10ps
`include "pps_consts.svh"
module pps_sequencer_tb;
	localparam int unsigned T2 = 5, T3 = 20, T4 = 4, T5 = 4, T12 = 8;
	logic clk = 0, srst = 1, rst_pin_n = 1, power_down_n = 1, emulation_strap = 0, slow = 0;
	logic video_valid = 0, video_sync_lost = 0, aux_req_valid = 0, i2c_req_valid = 0, sup_lo = 0;
	logic edid_req_valid = 0, edid_rsp_ready = 0;
	logic [9:0] edid_req_addr = 10'h0;
	pps_pkg::pps_reg_req_t aux_req = '0, i2c_req = '0;
	logic aux_req_ready, i2c_req_ready, rsp_valid_q, rsp_from_i2c_q, edid_req_ready, edid_rsp_valid;
	logic ddc_req_valid_q, ddc_rsp_valid, hot_plug_out_q, panel_power_en_q, backlight_en_q;
	logic lvds_drive_q, lvds_weak_pd_q, main_link_hiz_q;
	logic [7:0] rsp_data_q, edid_rsp_data, ddc_rsp_data, q;
	logic [9:0] ddc_req_addr_q;
	int n_fail = 0, tests_run = 0, n;
	wire [3:0] sq = {hot_plug_out_q, panel_power_en_q, lvds_drive_q, backlight_en_q};
	always #5 clk = ~clk;
	pps_sequencer #(.T2_CYCLES(T2), .T3_CYCLES(T3), .T4_CYCLES(T4), .T5_CYCLES(T5), .T12_CYCLES(T12)) dut_u (
		.clk(clk), .srst(srst), .rst_pin_n(rst_pin_n), .power_down_n(power_down_n),
		.emulation_strap(emulation_strap), .supply_above_high(!sup_lo), .supply_below_low(sup_lo),
		.video_valid(video_valid), .video_sync_lost(video_sync_lost), .aux_req_valid(aux_req_valid),
		.aux_req(aux_req), .aux_req_ready(aux_req_ready), .i2c_req_valid(i2c_req_valid), .i2c_req(i2c_req),
		.i2c_req_ready(i2c_req_ready), .rsp_valid_q(rsp_valid_q), .rsp_from_i2c_q(rsp_from_i2c_q),
		.rsp_data_q(rsp_data_q), .edid_req_valid(edid_req_valid), .edid_req_addr(edid_req_addr),
		.edid_req_ready(edid_req_ready), .edid_rsp_valid(edid_rsp_valid), .edid_rsp_data(edid_rsp_data),
		.edid_rsp_ready(edid_rsp_ready), .ddc_req_valid_q(ddc_req_valid_q), .ddc_req_addr_q(ddc_req_addr_q),
		.ddc_rsp_valid(ddc_rsp_valid), .ddc_rsp_data(ddc_rsp_data), .hot_plug_out_q(hot_plug_out_q),
		.panel_power_en_q(panel_power_en_q), .backlight_en_q(backlight_en_q), .lvds_drive_q(lvds_drive_q),
		.lvds_weak_pd_q(lvds_weak_pd_q), .main_link_hiz_q(main_link_hiz_q)
	);
	pps_panel_model panel_u (.clk(clk), .slow(slow), .ddc_req_valid_q(ddc_req_valid_q),
		.ddc_req_addr_q(ddc_req_addr_q), .ddc_rsp_valid(ddc_rsp_valid), .ddc_rsp_data(ddc_rsp_data));
	task automatic tally_and_finish;
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'h1)
		begin
			n_fail++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic acc(input logic i2c, wr, input logic [19:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		if (i2c)
		begin
			i2c_req_valid <= 1'h1;
			i2c_req <= '{wr, a, d};
		end
		else
		begin
			aux_req_valid <= 1'h1;
			aux_req <= '{wr, a, d};
		end
		do
		begin
			@(posedge clk);
			k++;
		end
		while ((i2c ? i2c_req_ready : aux_req_ready) !== 1'h1 && k < 50);
		aux_req_valid <= 1'h0;
		i2c_req_valid <= 1'h0;
		chk(k < 50, "request not taken");
		if (!wr)
		begin
			@(negedge clk);
			chk(rsp_valid_q === 1'h1 && rsp_from_i2c_q === i2c, "no read answer");
			q = rsp_data_q;
		end
	endtask
	task automatic rd(input logic i2c, input logic [19:0] a, input logic [7:0] e);
		acc(i2c, 1'h0, a, 8'h00);
		chk(q === e, "register value");
	endtask
	task automatic er(input logic [9:0] a);
		int k;
		k = 0;
		@(posedge clk);
		edid_req_valid <= 1'h1;
		edid_req_addr <= a;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (edid_req_ready !== 1'h1 && k < 50);
		edid_req_valid <= 1'h0;
		chk(k < 50, "id request not taken");
	endtask
	task automatic pop(input logic [7:0] e);
		int k;
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (edid_rsp_valid !== 1'h1 && k < 50);
		chk(edid_rsp_data === e && k < 50, "id byte");
		@(posedge clk);
		edid_rsp_ready <= 1'h1;
		@(posedge clk);
		edid_rsp_ready <= 1'h0;
	endtask
	task automatic wt(input int b, input logic v, input int lo, hi);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (sq[b] !== v && n < 3000);
		chk(n >= lo && n <= hi, "output timing");
	endtask
	task automatic t_start;
		repeat (16) @(posedge clk);
		srst <= 1'h0;
		wt(3, 1'h1, 1200, 1300);
		rd(1'h0, `PPS_ADDR_EMUL_CFG, `PPS_EMUL_CFG_RST);
		rd(1'h1, 20'h00300, 8'h00);
		acc(1'h1, 1'h1, `PPS_ADDR_LOCK_STATUS, 8'hFF);
		rd(1'h0, `PPS_ADDR_LOCK_STATUS, 8'h00);
	endtask
	task automatic t_edid;
		for (int i = 0; i < 16; i++)
			acc(i[0], 1'h1, `PPS_ADDR_EDID_BASE + 20'(i), 8'h30 + 8'(i));
		acc(1'h0, 1'h1, `PPS_ADDR_EDID_BASE + 20'h37F, 8'hC3);
		for (int i = 0; i < 16; i++)
			er(10'(i));
		@(posedge clk);
		edid_req_valid <= 1'h1;
		@(negedge clk);
		chk(edid_req_ready === 1'h0, "full buffer took request");
		@(posedge clk);
		edid_req_valid <= 1'h0;
		for (int i = 0; i < 16; i++)
			pop(8'h30 + 8'(i));
		er(10'h37F);
		pop(8'hC3);
	endtask
	task automatic t_pass;
		acc(1'h1, 1'h1, `PPS_ADDR_EMUL_CFG, 8'h02);
		slow <= 1'h1;
		er(10'h009);
		pop(8'hAC);
	endtask
	task automatic t_up;
		@(posedge clk);
		video_valid <= 1'h1;
		wt(2, 1'h1, 1, 20);
		wt(1, 1'h1, T2 - 1, T2 + 1);
		chk(lvds_weak_pd_q === 1'h0 && main_link_hiz_q === 1'h0, "lvds not driven");
		wt(0, 1'h1, T3 - 1, T3 + 1);
		rd(1'h0, `PPS_ADDR_LOCK_STATUS, 8'h01);
	endtask
	task automatic t_d3;
		acc(1'h0, 1'h1, `PPS_ADDR_POWER_STATE, `PPS_PWR_D3);
		wt(0, 1'h0, 1, 4);
		chk(lvds_drive_q === 1'h1, "lvds stopped first");
		wt(1, 1'h0, T4 - 1, T4 + 1);
		wt(2, 1'h0, T5 - 1, T5 + 1);
		chk(lvds_weak_pd_q & main_link_hiz_q & hot_plug_out_q, "low-power pins");
		@(posedge clk);
		i2c_req_valid <= 1'h1;
		@(negedge clk);
		chk(i2c_req_ready === 1'h0, "i2c open in low power");
		@(posedge clk);
		i2c_req_valid <= 1'h0;
		rd(1'h0, `PPS_ADDR_POWER_STATE, `PPS_PWR_D3);
		acc(1'h0, 1'h1, `PPS_ADDR_POWER_STATE, `PPS_PWR_D0);
		wt(2, 1'h1, 1, 40);
		wt(0, 1'h1, T2 + T3 - 2, T2 + T3 + 4);
	endtask
	task automatic t_loss;
		@(posedge clk);
		video_sync_lost <= 1'h1;
		wt(1, 1'h0, 1, 3);
		chk(backlight_en_q === 1'h0, "backlight on after loss");
		wt(2, 1'h0, T5 - 1, T5 + 2);
		@(posedge clk);
		video_sync_lost <= 1'h0;
		video_valid <= 1'h0;
	endtask
	task automatic t_deep;
		@(posedge clk);
		power_down_n <= 1'h0;
		rst_pin_n <= 1'h0;
		emulation_strap <= 1'h1;
		repeat (8) @(negedge clk);
		chk(sq === 4'h0 && aux_req_ready === 1'h0 && lvds_weak_pd_q === 1'h1, "deep sleep pins");
		@(posedge clk);
		power_down_n <= 1'h1;
		// reset pulse of 10 us after power-down released
		repeat (1000) @(posedge clk);
		rst_pin_n <= 1'h1;
		wt(3, 1'h1, 1, 2000);
		er(10'h003);
		pop(8'hA6);
	endtask
	task automatic t_dip;
		@(posedge clk);
		sup_lo <= 1'h1;
		repeat (150) @(posedge clk);
		sup_lo <= 1'h0;
		repeat (4) @(negedge clk);
		chk(hot_plug_out_q === 1'h1, "short supply dip reset the device");
		@(posedge clk);
		sup_lo <= 1'h1;
		wt(3, 1'h0, 200, 210);
		@(posedge clk);
		sup_lo <= 1'h0;
		wt(3, 1'h1, 1200, 1300);
	endtask
	initial
	begin
		t_start();
		t_edid();
		t_pass();
		t_up();
		t_d3();
		t_loss();
		t_deep();
		t_dip();
		tally_and_finish();
	end
	initial
	begin
		#200000;
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
